// [inc/ddl_params.svh]
// constants of the deskew delay-locked loop: sizes, counts and limits
`ifndef DDL_PARAMS_SVH
`define DDL_PARAMS_SVH

// ----------------------------------------------------------------
// delay line geometry
// ----------------------------------------------------------------
`define DDL_TAPS 64
`define DDL_TAP_BITS 6
`define DDL_TAP_RESET 6'h00
`define DDL_SYS_SYNC_TAPS 6'h02

// ----------------------------------------------------------------
// counters and limits, in cycles of the 125 MHz clock; lock hits and miss limit in input periods
// ----------------------------------------------------------------
`define DDL_CNT_BITS 8
`define DDL_CNT_MAX 8'hFF
`define DDL_ACT_WINDOW 8'h40
`define DDL_PERIOD_TOL 8'h02
`define DDL_LOCK_HITS 4'h4
`define DDL_MISS_LIMIT 4'h8

`endif

// [inc/ddl_pkg.sv]
// types shared by the deskew delay-locked loop
`include "ddl_params.svh"

package ddl_pkg;

	// deskew adjust setting
	typedef enum logic {
		DDL_SYSTEM_SYNC,
		DDL_SOURCE_SYNC
	} ddl_deskew_t;

	// loop control states
	typedef enum logic [1:0] {
		DDL_IDLE,
		DDL_ACQUIRE,
		DDL_LOCKED,
		DDL_LOST
	} ddl_state_t;

	// static configuration of the loop
	typedef struct packed {
		logic feedbackExternal;
		logic feedbackDoubled;
		logic cascaded;
		logic dedicatedInput;
		ddl_deskew_t deskewMode;
		logic dutyCorrect;
	} ddl_cfg_t;

	// status seen by the user fabric
	typedef struct packed {
		logic lockLost;
		logic [`DDL_CNT_BITS-1:0] period;
		logic [`DDL_TAP_BITS-1:0] tap;
	} ddl_status_t;

endpackage

// [hdl/ddl_delay_line.sv]
// sampled digital delay line with a selectable tap
`timescale 1ns/1ns
`include "ddl_params.svh"

module ddl_delay_line #(
	parameter int DEPTH = `DDL_TAPS,
	parameter int IDX_BITS = `DDL_TAP_BITS
) (
	input wire logic clock, // system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic sampleIn, // level fed into the line
	input wire logic [IDX_BITS-1:0] tapSel, // tap index, 0 is shortest
	output logic tapOut // registered level at the chosen tap
);

	logic [DEPTH-1:0] line_q;

	// ----------------------------------------------------------------
	// shift chain and tap register
	// ----------------------------------------------------------------
	// tap index 0 still costs two cycles, equal on every path that uses it
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			line_q <= '0;
			tapOut <= 1'b0;
		end else begin
			line_q <= {line_q[DEPTH-2:0], sampleIn};
			tapOut <= line_q[tapSel];
		end
	end

endmodule

// [hdl/ddl_deskew_dll.sv]
// deskew delay-locked loop: delay line control, lock, deskew adjust, duty conditioning
//
// Summary of operation
// RL1: feedback normally zero-phase output via global buffer
// RL2: doubled output may serve as feedback instead
// RL3: user resets after selector switch or gate enable
// RL4: user pulses reset after configuration with external feedback
// RL5: capture starts at startup, even while outputs tri-stated
// RL6: lock only with both clocks present and stable
// RL7: grow delay until rising edges coincide, then lock
// RL8: keep sampling both clocks and trimming delay
// RL9: lock indicator qualifies output, also inverted form
// RL10: system-synchronous adds delay on feedback path
// RL11: no extra delay if cascaded, external, non-dedicated
// RL12: source-synchronous adds no skew; user phase-shifts
// RL13: condition outputs to half-period high and low
// RL14: lock drops on input drift; reset reacquires
// RL15: reset clears lock and delay, restarts acquisition
`timescale 1ns/1ns
`include "ddl_params.svh"

module ddl_deskew_dll (
	input wire logic clock, // 125 MHz system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic startup, // device has entered its startup sequence
	input wire logic inputClock, // sampled input clock
	input wire logic feedbackClock, // sampled feedback clock from distribution
	input wire ddl_pkg::ddl_cfg_t cfg, // static configuration
	output logic zeroPhaseOut, // deskewed, conditioned output clock
	output logic doubledOut, // frequency-doubled output clock
	output logic lockedOut, // lock indicator, active high
	output logic lockedN, // lock indicator for active-low enables
	output ddl_pkg::ddl_status_t status // tap, period and lost flag
);
	import ddl_pkg::*;

	localparam int TB = `DDL_TAP_BITS;
	localparam int CB = `DDL_CNT_BITS;

	ddl_state_t state_q, state_d;
	logic [TB-1:0] tap_q, tap_d, tapUp, tapDown, fbTap;
	logic [CB-1:0] period_q, perCnt_q, lockPeriod_q, inAct_q, fbAct_q, phaseCnt_q, phaseCnt_d;
	logic [3:0] hits_q, hits_d, misses_q, misses_d;
	logic inPrev_q, fbPrev_q, rawPrev_q, fbRiseDly_q, lateWin_q, zeroPhase_q, doubled_q;
	logic rawOut, fbDelayed, inRise, fbRise, rawRise, bothPresent, sysDelayOn, drifted;
	logic [CB-1:0] half, quarter;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// step the delay setting by one tap, wrapping at both ends of the line
	function automatic logic [TB-1:0] tapStep(input logic [TB-1:0] t, input logic up);
		tapStep = up ? t + 1'b1 : t - 1'b1;
	endfunction

	// saturating increment of a cycle counter
	function automatic logic [CB-1:0] satInc(input logic [CB-1:0] c);
		satInc = (c == `DDL_CNT_MAX) ? c : c + 1'b1;
	endfunction

	// ----------------------------------------------------------------
	// delay lines
	// ----------------------------------------------------------------
	// forward line: input clock delayed by the loop setting
	ddl_delay_line #(.DEPTH(`DDL_TAPS), .IDX_BITS(TB)) uFwd (
		.clock(clock),
		.nrst(nrst),
		.sampleIn(inputClock),
		.tapSel(tap_q),
		.tapOut(rawOut)
	);

	// feedback line: the extra hold-time delay only applies where it can be characterised
	assign sysDelayOn = (cfg.deskewMode == DDL_SYSTEM_SYNC) && !cfg.cascaded
		&& !cfg.feedbackExternal && cfg.dedicatedInput; // RL10 RL11 RL12
	assign fbTap = sysDelayOn ? `DDL_SYS_SYNC_TAPS : `DDL_TAP_RESET; // RL10 RL11 RL12

	ddl_delay_line #(.DEPTH(`DDL_TAPS), .IDX_BITS(TB)) uFb (
		.clock(clock),
		.nrst(nrst),
		.sampleIn(feedbackClock),
		.tapSel(fbTap),
		.tapOut(fbDelayed)
	);

	// ----------------------------------------------------------------
	// edge detection, activity and period measurement
	// ----------------------------------------------------------------
	// with doubled feedback only the edge nearest the input edge is compared
	assign inRise = inputClock && !inPrev_q;
	assign fbRise = fbDelayed && !fbPrev_q;
	assign rawRise = rawOut && !rawPrev_q;
	assign bothPresent = (inAct_q < `DDL_ACT_WINDOW) && (fbAct_q < `DDL_ACT_WINDOW); // RL6
	assign drifted = (period_q > lockPeriod_q + `DDL_PERIOD_TOL)
		|| (period_q + `DDL_PERIOD_TOL < lockPeriod_q); // RL14
	assign tapUp = tapStep(tap_q, 1'b1);
	assign tapDown = tapStep(tap_q, 1'b0);

	// edge history, activity timers and input period
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			inPrev_q <= 1'b0;
			fbPrev_q <= 1'b0;
			rawPrev_q <= 1'b0;
			fbRiseDly_q <= 1'b0;
			lateWin_q <= 1'b0;
			inAct_q <= `DDL_CNT_MAX;
			fbAct_q <= `DDL_CNT_MAX;
			perCnt_q <= '0;
			period_q <= '0;
		end else begin
			inPrev_q <= inputClock;
			fbPrev_q <= fbDelayed;
			rawPrev_q <= rawOut;
			fbRiseDly_q <= fbRise;
			lateWin_q <= inRise && !fbRise;
			inAct_q <= inRise ? '0 : satInc(inAct_q);
			fbAct_q <= fbRise ? '0 : satInc(fbAct_q);
			perCnt_q <= inRise ? '0 : satInc(perCnt_q);
			period_q <= inRise ? satInc(perCnt_q) : period_q;
		end
	end

	// ----------------------------------------------------------------
	// loop control
	// ----------------------------------------------------------------
	// acquisition grows the delay; tracking trims it either way
	always_comb begin
		state_d = state_q;
		tap_d = tap_q;
		hits_d = hits_q;
		misses_d = misses_q;
		case (state_q)
			DDL_IDLE: begin
				if (startup) begin
					state_d = DDL_ACQUIRE; // RL5
				end
			end
			DDL_ACQUIRE: begin
				if (inRise && bothPresent) begin // RL6
					if (fbRise) begin
						hits_d = hits_q + 1'b1;
						if (hits_q == `DDL_LOCK_HITS - 1'b1) begin
							state_d = DDL_LOCKED; // RL7
						end
					end else begin
						hits_d = '0;
						tap_d = tapUp; // RL7
					end
				end
			end
			DDL_LOCKED: begin
				if (inRise) begin
					if (drifted || !bothPresent) begin
						state_d = DDL_LOST; // RL14
					end else if (fbRise) begin
						misses_d = '0;
					end else begin
						misses_d = misses_q + 1'b1;
						if (fbRiseDly_q) begin
							tap_d = tapUp; // RL8
						end
						if (misses_q == `DDL_MISS_LIMIT - 1'b1) begin
							state_d = DDL_LOST; // RL14
						end
					end
				end else if (lateWin_q && fbRise) begin
					tap_d = tapDown; // RL8
				end
			end
			DDL_LOST: begin
				state_d = DDL_LOST; // RL14
			end
			default: begin
				state_d = DDL_IDLE;
			end
		endcase
	end

	// loop state; reset returns the line to its shortest setting
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q <= DDL_IDLE; // RL15
			tap_q <= `DDL_TAP_RESET; // RL15
			hits_q <= '0;
			misses_q <= '0;
			lockPeriod_q <= '0;
		end else begin
			state_q <= state_d;
			tap_q <= tap_d;
			hits_q <= hits_d;
			misses_q <= misses_d;
			lockPeriod_q <= (state_q != DDL_LOCKED) ? period_q : lockPeriod_q;
		end
	end

	// ----------------------------------------------------------------
	// duty conditioning and doubling
	// ----------------------------------------------------------------
	// outputs are rebuilt from the delayed rising edge and the measured period
	assign half = period_q >> 1;
	assign quarter = period_q >> 2;
	assign phaseCnt_d = rawRise ? '0 : satInc(phaseCnt_q);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			phaseCnt_q <= `DDL_CNT_MAX;
			zeroPhase_q <= 1'b0;
			doubled_q <= 1'b0;
		end else begin
			phaseCnt_q <= phaseCnt_d;
			zeroPhase_q <= cfg.dutyCorrect ? (phaseCnt_d < half) : rawOut; // RL13
			doubled_q <= (phaseCnt_d < quarter) || ((phaseCnt_d >= half) && (phaseCnt_d < half + quarter));
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign zeroPhaseOut = zeroPhase_q;
	assign doubledOut = doubled_q;
	assign lockedOut = (state_q == DDL_LOCKED); // RL9
	assign lockedN = !lockedOut; // RL9
	assign status = '{lockLost: (state_q == DDL_LOST), period: period_q, tap: tap_q};

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_resetClear;
		$rose(nrst) |-> (tap_q == `DDL_TAP_RESET) && !lockedOut && (state_q == DDL_IDLE);
	endproperty
	a_resetClear: assert property (p_resetClear) else $error("reset left lock or delay set"); // RL15

	property p_startCapture;
		(state_q == DDL_IDLE) && startup |=> (state_q == DDL_ACQUIRE);
	endproperty
	a_startCapture: assert property (p_startCapture) else $error("capture did not start"); // RL5

	property p_holdWhenAbsent;
		(state_q == DDL_ACQUIRE) && !bothPresent |=> $stable(tap_q) && !lockedOut;
	endproperty
	a_holdWhenAbsent: assert property (p_holdWhenAbsent) else $error("delay moved without both clocks"); // RL6

	property p_growOnMiss;
		(state_q == DDL_ACQUIRE) && inRise && bothPresent && !fbRise |=> tap_q == $past(tapUp);
	endproperty
	a_growOnMiss: assert property (p_growOnMiss) else $error("delay not grown on miss"); // RL7

	property p_trackLate;
		(state_q == DDL_LOCKED) && !inRise && lateWin_q && fbRise |=> tap_q == $past(tapDown);
	endproperty
	a_trackLate: assert property (p_trackLate) else $error("late feedback not trimmed"); // RL8

	property p_lockOnCoincide;
		$rose(lockedOut) |-> $past(inRise) && $past(fbRise) && (lockedN == 1'b0);
	endproperty
	a_lockOnCoincide: assert property (p_lockOnCoincide) else $error("lock without aligned edges"); // RL7 RL9

	property p_noExtraDelay;
		cfg.feedbackExternal || cfg.cascaded || !cfg.dedicatedInput
			|| (cfg.deskewMode == DDL_SOURCE_SYNC) |-> (fbTap == `DDL_TAP_RESET);
	endproperty
	a_noExtraDelay: assert property (p_noExtraDelay) else $error("extra feedback delay applied"); // RL11 RL12

	property p_sysDelay;
		(cfg.deskewMode == DDL_SYSTEM_SYNC) && !cfg.feedbackExternal && !cfg.cascaded
			&& cfg.dedicatedInput |-> (fbTap == `DDL_SYS_SYNC_TAPS);
	endproperty
	a_sysDelay: assert property (p_sysDelay) else $error("system delay missing"); // RL10

	property p_dutyHalf;
		cfg.dutyCorrect && !rawRise && (phaseCnt_d == half) |=> !zeroPhaseOut;
	endproperty
	a_dutyHalf: assert property (p_dutyHalf) else $error("output high past half period"); // RL13

	property p_lostSticky;
		(state_q == DDL_LOST) |=> (state_q == DDL_LOST) && !lockedOut && status.lockLost;
	endproperty
	a_lostSticky: assert property (p_lostSticky) else $error("lock recovered without reset"); // RL14

	c_lock: cover property ($rose(lockedOut));
	c_lost: cover property ((state_q == DDL_LOCKED) ##1 (state_q == DDL_LOST));
	c_trackUp: cover property ((state_q == DDL_LOCKED) && inRise && !fbRise && fbRiseDly_q);
	c_dutyRun: cover property (cfg.dutyCorrect && $rose(zeroPhaseOut));

endmodule

// [sim/ddl_clock_net.sv]
// model of the clock network that returns the feedback clock
`timescale 1ns/1ns

module ddl_clock_net (
	input wire logic clock, // system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic zeroPhase, // zero-phase output of the loop
	input wire logic doubled, // doubled output of the loop
	input wire logic useDoubled, // return the doubled output instead
	input wire logic present, // output buffers active
	input wire logic [3:0] distDelay, // distribution delay in cycles, minus one
	output logic feedbackClock // clock seen at the feedback tap
);
	logic [15:0] pipeQ;
	logic lastQ;

	// distribution delay, fed from the selected loop output
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pipeQ <= 16'h0000;
			lastQ <= 1'b1; // a pad that floats from reset idles low, so no false edge appears
		end else begin
			pipeQ <= {pipeQ[14:0], useDoubled ? doubled : zeroPhase};
			lastQ <= present ? pipeQ[distDelay] : lastQ;
		end
	end
	// a floating pad holds no clean level: show the inverse of the last one
	assign feedbackClock = present ? pipeQ[distDelay] : ~lastQ;
endmodule

// [sim/tb_top.sv]
// self-checking bench for the deskew delay-locked loop
`timescale 1ns/1ns

module tb_top;
	import ddl_pkg::*;
	logic clock, nrst, startup, inputClock, feedbackClock, useDoubled, present;
	logic zeroPhaseOut, doubledOut, lockedOut, lockedN;
	ddl_cfg_t cfg;
	ddl_status_t status;
	int hiLen, loLen, phase, cycles, errCount, testsRun, highs, rises;
	logic [5:0] tapSys, tapSrc;

	// ----------------------------------------
	// clocks, timeout and instances
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// input clock as a sampled level: hiLen high, loLen low
	always @(posedge clock) begin
		#1;
		phase = (phase >= hiLen + loLen - 1) ? 0 : phase + 1;
		inputClock = (phase < hiLen);
		cycles++;
		if (cycles >= 40000) begin
			errCount++;
			endSim();
		end
	end
	ddl_deskew_dll dut (.clock(clock), .nrst(nrst), .startup(startup), .inputClock(inputClock),
		.feedbackClock(feedbackClock), .cfg(cfg), .zeroPhaseOut(zeroPhaseOut), .doubledOut(doubledOut),
		.lockedOut(lockedOut), .lockedN(lockedN), .status(status));
	ddl_clock_net net (.clock(clock), .nrst(nrst), .zeroPhase(zeroPhaseOut), .doubled(doubledOut),
		.useDoubled(useDoubled), .present(present), .distDelay(4'h3), .feedbackClock(feedbackClock));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// pulse reset for three cycles, startup stays as set
	task automatic restart();
		nrst = 1'b0;
		tick(3);
		nrst = 1'b1;
	endtask
	task automatic waitLock();
		int n;
		n = 0;
		while (lockedOut !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		chk(16'(lockedOut), 16'h0001);
	endtask
	// high cycles of the output and rises of the doubled clock in one period
	task automatic countWave();
		logic prev;
		highs = 0;
		rises = 0;
		prev = doubledOut;
		repeat (16) begin
			tick(1);
			highs += (zeroPhaseOut === 1'b1);
			rises += (doubledOut === 1'b1 && prev === 1'b0);
			prev = doubledOut;
		end
	endtask
	task automatic endSim();
		$display("checks %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic testStartup();
		chk(16'({lockedOut, lockedN}), 16'h0001);
		chk(16'(status), 16'h0000);
		nrst = 1'b1;
		tick(300);
		chk(16'({lockedOut, status.tap}), 16'h0000);
		startup = 1'b1;
		waitLock();
		chk(16'(lockedN), 16'h0000);
		chk(16'(status.period), 16'h0010);
		tapSys = status.tap;
		$display("test startup done");
	endtask
	task automatic testDeskew();
		cfg.deskewMode = DDL_SOURCE_SYNC;
		restart();
		waitLock();
		tapSrc = status.tap;
		chk(16'(tapSys + 6'h02), 16'(tapSrc));
		cfg.deskewMode = DDL_SYSTEM_SYNC;
		cfg.cascaded = 1'b1;
		restart();
		waitLock();
		chk(16'(status.tap), 16'(tapSrc));
		cfg.cascaded = 1'b0;
		cfg.dedicatedInput = 1'b0;
		restart();
		waitLock();
		chk(16'(status.tap), 16'(tapSrc));
		cfg.dedicatedInput = 1'b1;
		$display("test deskew done");
	endtask
	task automatic testDuty();
		restart();
		waitLock();
		countWave();
		chk(16'(highs), 16'h0008);
		chk(16'(rises), 16'h0002);
		cfg.dutyCorrect = 1'b0;
		tick(32);
		countWave();
		chk(16'(highs), 16'h0004);
		cfg.dutyCorrect = 1'b1;
		$display("test duty done");
	endtask
	task automatic testExternal();
		cfg.feedbackExternal = 1'b1;
		present = 1'b0;
		restart();
		tick(400);
		chk(16'({lockedOut, status.tap}), 16'h0000);
		present = 1'b1;
		restart();
		waitLock();
		chk(16'(status.tap), 16'(tapSrc));
		useDoubled = 1'b1;
		cfg.feedbackDoubled = 1'b1;
		restart();
		waitLock();
		useDoubled = 1'b0;
		cfg.feedbackDoubled = 1'b0;
		cfg.feedbackExternal = 1'b0;
		$display("test external done");
	endtask
	task automatic testDrift();
		restart();
		waitLock();
		loLen = 16;
		tick(80);
		chk(16'({lockedOut, status.lockLost}), 16'h0001);
		loLen = 12;
		tick(100);
		chk(16'(lockedOut), 16'h0000);
		restart();
		waitLock();
		$display("test drift done");
	endtask
	// one short input period: late feedback trims a tap, the early one after it restores the tap
	task automatic testTrack();
		restart();
		waitLock();
		while (phase != 1) begin
			tick(1);
		end
		loLen = 11;
		tick(1);
		while (phase != 1) begin
			tick(1);
		end
		loLen = 12;
		tick(4);
		chk(16'({lockedOut, status.tap}), 16'({1'b1, tapSys - 6'h01}));
		tick(32);
		chk(16'({lockedOut, status.tap}), 16'({1'b1, tapSys}));
		$display("test track done");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		startup = 1'b0;
		useDoubled = 1'b0;
		present = 1'b1;
		hiLen = 4;
		loLen = 12;
		phase = 0;
		cycles = 0;
		errCount = 0;
		testsRun = 0;
		cfg = '{1'b0, 1'b0, 1'b0, 1'b1, DDL_SYSTEM_SYNC, 1'b1};
		tick(3);
		testStartup();
		testDeskew();
		testDuty();
		testExternal();
		testTrack();
		testDrift();
		endSim();
	end
endmodule
